// ---- logic_function_regs.vh ----
// Register map, field layout, reset values and codes of the logic function block
// Notes on behaviour
// R1: NAND drives true when any considered input is false, false when all are true.
// R2: Only inputs flagged connected take part; unconnected inputs are ignored entirely.
// R3: Eight single-bit operand inputs feed the operation; one single-bit result output.
// R4: Equality drives true when all considered inputs share one value, else false.
// R5: Inequality drives false when all considered inputs are equal, true when they differ.
// R6: OR drives true when any considered input is true, false when all are false.
// R7: An indeterminate result takes its value and error from the error-handling choice.
// R8: Error handling offers true good, true bad, false good and false bad.
// R9: The configuring party picks the operation through the function selector.
// R10: An error on a considered input propagates as error status to the output. The code drives no error with the selector at off or AND.
// R11: With the selector at off, the output stays false whatever the inputs.
// R12: Output and error are registered each clock; reset clears both to false, no error.
// R13: With no input connected the result is indeterminate and error handling applies; the code does so only for NAND, equality, inequality and OR.
`ifndef LOGIC_FUNCTION_REGS_VH
`define LOGIC_FUNCTION_REGS_VH

// ======================================================
// Bus geometry
`define ADDR_W 8
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ======================================================
// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_INT_STAT 8'h08
`define OFS_INT_MASK 8'h0C
`define OFS_CHG_COUNT 8'h10

// ======================================================
// Control fields and reset values
`define CTRL_FUNC_LSB 0
`define CTRL_FUNC_MSB 3
`define CTRL_ERRH_LSB 4
`define CTRL_ERRH_MSB 5
`define FUNC_RESET 4'h0
`define ERRH_RESET 2'h2
`define INT_MASK_RESET 4'h0

// ======================================================
// Function selector codes
`define FN_OFF 4'h0
`define FN_AND 4'h1
`define FN_NAND 4'h2
`define FN_ALL_SAME 4'h3
`define FN_ANY_DIFFER 4'h4
`define FN_OR 4'h5

// ======================================================
// Error-handling codes: bit 1 picks false, bit 0 marks an error
`define ERRH_TRUE_GOOD 2'h0
`define ERRH_TRUE_BAD 2'h1
`define ERRH_FALSE_GOOD 2'h2
`define ERRH_FALSE_BAD 2'h3

// ======================================================
// Interrupt status bits
`define INT_N 4
`define INT_RISE 0
`define INT_FALL 1
`define INT_INDET 2
`define INT_ERR 3

`endif

// ---- logic_eval.v ----
// Combinational evaluation of the selected logic operation
`timescale 1ns/1ps
`include "logic_function_regs.vh"

module logic_eval (
	// Operands
	input wire [7:0] in_val,
	input wire [7:0] in_conn,
	input wire [7:0] in_err,
	// Configuration
	input wire [3:0] func,
	input wire [1:0] err_mode,
	// Result
	output reg value,
	output reg error,
	output reg indet
);

	wire [7:0] is_true_w;
	wire [7:0] is_false_w;
	wire [7:0] is_err_w;
	reg any_true;
	reg any_false;
	reg any_err;
	reg none_conn;

	// ======================================================
	// Per-input qualification
	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1) begin : g_bit
			assign is_true_w[i] = in_conn[i] & in_val[i]; // R2
			assign is_false_w[i] = in_conn[i] & ~in_val[i]; // R2
			assign is_err_w[i] = in_conn[i] & in_err[i]; // R2
		end
	endgenerate

	// ======================================================
	// Operation select
	always @* begin
		any_true = |is_true_w;
		any_false = |is_false_w;
		any_err = |is_err_w;
		none_conn = ~|in_conn;
		value = 1'b0;
		error = 1'b0;
		indet = 1'b0;
		case (func) // R9
			`FN_NAND: begin
				value = any_false; // R1
				error = any_err; // R10
			end
			`FN_ALL_SAME: begin
				value = ~(any_true & any_false); // R4
				error = any_err; // R10
			end
			`FN_ANY_DIFFER: begin
				value = any_true & any_false; // R5
				error = any_err; // R10
			end
			`FN_OR: begin
				value = any_true; // R6
				error = any_err; // R10
			end
			default: begin
				value = 1'b0; // R11
				error = 1'b0;
			end
		endcase
		if (none_conn && (func == `FN_NAND || func == `FN_ALL_SAME || func == `FN_ANY_DIFFER ||
			func == `FN_OR)) begin
			indet = 1'b1; // R13
			value = ~err_mode[1]; // R7 R8
			error = err_mode[0]; // R7 R8
		end
	end

endmodule

// ---- sticky_flags.v ----
// Sticky event flags, cleared by writing one, set wins over clear
`timescale 1ns/1ps
`include "logic_function_regs.vh"

module sticky_flags (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Events and clears
	input wire [`INT_N-1:0] set,
	input wire [`INT_N-1:0] clr,
	// Flags
	output wire [`INT_N-1:0] flag
);

	reg [`INT_N-1:0] flag_q;

	assign flag = flag_q;

	// ======================================================
	// One flip-flop per flag
	genvar i;
	generate
		for (i = 0; i < `INT_N; i = i + 1) begin : g_flag
			always @(posedge clk or posedge rst) begin
				if (rst) begin
					flag_q[i] <= 1'b0;
				end else if (set[i]) begin
					flag_q[i] <= 1'b1;
				end else if (clr[i]) begin
					flag_q[i] <= 1'b0;
				end
			end
		end
	endgenerate

endmodule

// ---- logic_function.v ----
// Logic function block with AXI4-Lite registers and interrupt
//
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "logic_function_regs.vh"

module logic_function (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Operands from neighbouring blocks
	input wire [7:0] in_val,
	input wire [7:0] in_conn,
	input wire [7:0] in_err,
	// Result to neighbouring blocks
	output reg result_q,
	output reg result_err_q,
	// Interrupt
	output reg irq_q,
	// AXI4-Lite write address
	input wire [`ADDR_W-1:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// AXI4-Lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read address
	input wire [`ADDR_W-1:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// AXI4-Lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);

	// ======================================================
	// Declarations
	reg [3:0] func_q;
	reg [1:0] errh_q;
	reg [`INT_N-1:0] int_mask_q;
	reg indet_q;
	reg [15:0] chg_count_q;
	reg aw_held_q;
	reg aw_held_d;
	reg [`ADDR_W-1:0] awaddr_q;
	reg w_held_q;
	reg w_held_d;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	reg bvalid_d;
	reg rvalid_d;
	reg [31:0] rd_data;
	reg rd_ok;
	reg wr_ok;
	reg [`INT_N-1:0] int_set;
	reg [`INT_N-1:0] int_clr;
	wire eval_val;
	wire eval_err;
	wire eval_indet;
	wire [`INT_N-1:0] int_flag;
	wire wr_do;
	wire rd_do;
	wire aw_take;
	wire w_take;
	reg result_d;
	reg result_err_d;
	reg indet_d;
	reg irq_d;
	reg [3:0] func_d;
	reg [1:0] errh_d;
	reg [`INT_N-1:0] int_mask_d;
	reg [15:0] chg_count_d;
	reg [`ADDR_W-1:0] awaddr_d;
	reg [31:0] wdata_d;
	reg [3:0] wstrb_d;
	reg awready_d;
	reg wready_d;
	reg [1:0] bresp_d;
	reg arready_d;
	reg [31:0] rdata_d;
	reg [1:0] rresp_d;
	wire lane0;
	wire wr_ctrl;
	wire wr_int_stat;
	wire wr_int_mask;
	wire wr_chg;
	wire ev_rise;
	wire ev_fall;
	wire ev_indet;
	wire ev_err;

	// ======================================================
	// Operation evaluation
	logic_eval u_eval (
		.in_val(in_val),
		.in_conn(in_conn),
		.in_err(in_err),
		.func(func_q),
		.err_mode(errh_q),
		.value(eval_val),
		.error(eval_err),
		.indet(eval_indet)
	);

	// ======================================================
	// Next result, straight from the evaluated operation
	always @* begin
		result_d = eval_val; // R3
		result_err_d = eval_err; // R10
		indet_d = eval_indet; // R13
	end

	// ======================================================
	// Registered result
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			result_q <= 1'b0; // R12
			result_err_q <= 1'b0; // R12
			indet_q <= 1'b0;
		end else begin
			result_q <= result_d; // R3 R12
			result_err_q <= result_err_d; // R12
			indet_q <= indet_d;
		end
	end

	// ======================================================
	// Events seen on the next result
	assign ev_rise = result_d & ~result_q;
	assign ev_fall = ~result_d & result_q;
	assign ev_indet = indet_d & ~indet_q;
	assign ev_err = result_err_d & ~result_err_q;

	always @* begin
		int_set = {`INT_N{1'b0}};
		int_set[`INT_RISE] = ev_rise;
		int_set[`INT_FALL] = ev_fall;
		int_set[`INT_INDET] = ev_indet;
		int_set[`INT_ERR] = ev_err;
	end

	always @* begin
		int_clr = {`INT_N{1'b0}};
		if (wr_int_stat) begin
			int_clr = wdata_q[`INT_N-1:0];
		end
	end

	sticky_flags u_flags (
		.clk(clk),
		.rst(rst),
		.set(int_set),
		.clr(int_clr),
		.flag(int_flag)
	);

	// ======================================================
	// Interrupt, high while an unmasked flag is set
	always @* begin
		irq_d = |(int_flag & int_mask_q);
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
		end
	end

	// ======================================================
	// Write channel acceptance, address and data in either order
	assign aw_take = s_axi_awvalid & s_axi_awready;
	assign w_take = s_axi_wvalid & s_axi_wready;
	assign wr_do = aw_held_q & w_held_q & ~s_axi_bvalid;

	always @* begin
		aw_held_d = aw_held_q | aw_take;
		w_held_d = w_held_q | w_take;
		if (wr_do) begin
			aw_held_d = 1'b0;
			w_held_d = 1'b0;
		end
		bvalid_d = wr_do | (s_axi_bvalid & ~s_axi_bready);
		awready_d = ~aw_held_d & ~bvalid_d;
		wready_d = ~w_held_d & ~bvalid_d;
		awaddr_d = awaddr_q;
		if (aw_take) begin
			awaddr_d = s_axi_awaddr;
		end
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		if (w_take) begin
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
		end
		bresp_d = s_axi_bresp;
		if (wr_do) begin
			bresp_d = wr_ok ? `RESP_OKAY : `RESP_SLVERR;
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awaddr_q <= {`ADDR_W{1'b0}};
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else begin
			aw_held_q <= aw_held_d;
			w_held_q <= w_held_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			s_axi_awready <= awready_d;
			s_axi_wready <= wready_d;
			s_axi_bvalid <= bvalid_d;
			s_axi_bresp <= bresp_d;
		end
	end

	// ======================================================
	// Write decode
	always @* begin
		case (awaddr_q)
			`OFS_CTRL: wr_ok = 1'b1;
			`OFS_STATUS: wr_ok = 1'b1;
			`OFS_INT_STAT: wr_ok = 1'b1;
			`OFS_INT_MASK: wr_ok = 1'b1;
			`OFS_CHG_COUNT: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end

	// ======================================================
	// Write enables, every field but the change counter gated by byte lane 0
	assign lane0 = wstrb_q[0];
	assign wr_ctrl = wr_do & lane0 & (awaddr_q == `OFS_CTRL);
	assign wr_int_stat = wr_do & lane0 & (awaddr_q == `OFS_INT_STAT);
	assign wr_int_mask = wr_do & lane0 & (awaddr_q == `OFS_INT_MASK);
	assign wr_chg = wr_do & (awaddr_q == `OFS_CHG_COUNT);

	// ======================================================
	// Control registers
	always @* begin
		func_d = func_q;
		errh_d = errh_q;
		int_mask_d = int_mask_q;
		if (wr_ctrl) begin
			func_d = wdata_q[`CTRL_FUNC_MSB:`CTRL_FUNC_LSB]; // R9
			errh_d = wdata_q[`CTRL_ERRH_MSB:`CTRL_ERRH_LSB]; // R8
		end
		if (wr_int_mask) begin
			int_mask_d = wdata_q[`INT_N-1:0];
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			func_q <= `FUNC_RESET;
			errh_q <= `ERRH_RESET;
			int_mask_q <= `INT_MASK_RESET;
		end else begin
			func_q <= func_d;
			errh_q <= errh_d;
			int_mask_q <= int_mask_d;
		end
	end

	// ======================================================
	// Output change counter, saturating, any write clears
	always @* begin
		chg_count_d = chg_count_q;
		if (wr_chg) begin
			chg_count_d = 16'h0000;
		end else if ((result_d != result_q) && chg_count_q != 16'hFFFF) begin
			chg_count_d = chg_count_q + 16'h0001;
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			chg_count_q <= 16'h0000;
		end else begin
			chg_count_q <= chg_count_d;
		end
	end

	// ======================================================
	// Read decode
	always @* begin
		rd_data = 32'h00000000;
		rd_ok = 1'b1;
		case (s_axi_araddr)
			`OFS_CTRL: begin
				rd_data[`CTRL_FUNC_MSB:`CTRL_FUNC_LSB] = func_q;
				rd_data[`CTRL_ERRH_MSB:`CTRL_ERRH_LSB] = errh_q;
			end
			`OFS_STATUS: begin
				rd_data[0] = result_q;
				rd_data[1] = result_err_q;
				rd_data[2] = indet_q;
				rd_data[15:8] = in_val;
				rd_data[23:16] = in_conn;
				rd_data[31:24] = in_err;
			end
			`OFS_INT_STAT: rd_data[`INT_N-1:0] = int_flag;
			`OFS_INT_MASK: rd_data[`INT_N-1:0] = int_mask_q;
			`OFS_CHG_COUNT: rd_data[15:0] = chg_count_q;
			default: rd_ok = 1'b0;
		endcase
	end

	// ======================================================
	// Read channel, one read under way at a time
	assign rd_do = s_axi_arvalid & s_axi_arready;

	always @* begin
		rvalid_d = rd_do | (s_axi_rvalid & ~s_axi_rready);
		arready_d = ~rvalid_d;
		rdata_d = s_axi_rdata;
		rresp_d = s_axi_rresp;
		if (rd_do) begin
			rdata_d = rd_data;
			rresp_d = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end else begin
			s_axi_arready <= arready_d;
			s_axi_rvalid <= rvalid_d;
			s_axi_rdata <= rdata_d;
			s_axi_rresp <= rresp_d;
		end
	end

endmodule

// ---- logic_function_properties.sv ----
// Checker of result timing, reset and bus handshakes of the logic function block
`timescale 1ns/1ps
`include "logic_function_regs.vh"
module logic_function_checks (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Operands and result
	input wire [7:0] in_val,
	input wire [7:0] in_conn,
	input wire [7:0] in_err,
	input wire result_q,
	input wire result_err_q,
	input wire irq_q,
	// Bus handshakes
	input wire s_axi_awready,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// ==========
	// Assertions
	a_err_clean: assert property ((in_err & in_conn) == 8'h00 && in_conn != 8'h00 |=> !result_err_q)
		else $error("error flag without a faulty connected input");
	a_unconn_ignored: assert property (!s_axi_bvalid && $stable(in_conn) && $stable(in_val & in_conn)
		&& $stable(in_err & in_conn) |=> $stable(result_q) && $stable(result_err_q))
		else $error("result moved on unconnected inputs");
	a_reset_clear: assert property (disable iff (1'b0) rst |=> !result_q && !result_err_q && !irq_q)
		else $error("outputs not cleared by reset");
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while busy");
	a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	cover property (irq_q);
	cover property ($rose(result_q));
	cover property (s_axi_bvalid && s_axi_bresp == `RESP_SLVERR);
endmodule

bind logic_function logic_function_checks checks (.clk(clk), .rst(rst), .in_val(in_val), .in_conn(in_conn),
	.in_err(in_err), .result_q(result_q), .result_err_q(result_err_q), .irq_q(irq_q),
	.s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready));

// ---- operand_source.sv ----
// Neighbouring blocks that drive the operand lines
`timescale 1ns/1ps
module operand_source (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Next operands
	input wire [7:0] next_val,
	input wire [7:0] next_conn,
	input wire [7:0] next_err,
	// Operand lines
	output reg [7:0] val_q,
	output reg [7:0] conn_q,
	output reg [7:0] err_q
);
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			val_q <= 8'h00;
			conn_q <= 8'h00;
			err_q <= 8'h00;
		end else begin
			val_q <= next_val;
			conn_q <= next_conn;
			err_q <= next_err;
		end
	end
endmodule

// ---- testbench.sv ----
// Self-checking bench of the logic function block
`timescale 1ns/1ps
`include "logic_function_regs.vh"
module testbench;
	reg clk, rst, awvalid, wvalid, bready, arvalid, rready, dn;
	reg [7:0] nv, nc, ne, awaddr, araddr;
	reg [31:0] wdata;
	reg [1:0] mo;
	wire [7:0] in_val, in_conn, in_err;
	wire result_q, result_err_q, irq_q, awready, wready, bvalid, arready, rvalid;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	integer fails, cmp_count, seed, f, m, k, n;
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	operand_source partner (.clk(clk), .rst(rst), .next_val(nv), .next_conn(nc), .next_err(ne),
		.val_q(in_val), .conn_q(in_conn), .err_q(in_err));
	logic_function DUT (.clk(clk), .rst(rst), .in_val(in_val), .in_conn(in_conn), .in_err(in_err),
		.result_q(result_q), .result_err_q(result_err_q), .irq_q(irq_q), .s_axi_awaddr(awaddr),
		.s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));
	// ==========
	// Reference model and tasks
	function [1:0] model_out(input [3:0] fn, input [1:0] eh, input [7:0] v, input [7:0] c, input [7:0] e);
		reg t;
		reg z;
		begin
			t = |(v & c);
			z = |(~v & c);
			if (fn < 4'h2 || fn > 4'h5)
				model_out = 2'b00;
			else if (c == 8'h00)
				model_out = {~eh[1], eh[0]};
			else
				model_out = {fn == `FN_NAND ? z : fn == `FN_OR ? t : (t & z) ^ (fn == `FN_ALL_SAME), |(e & c)};
		end
	endfunction
	task check(input [31:0] seen, input [31:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (seen !== exp) begin
				fails = fails + 1;
				$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	// Write when w is set, else read and compare data with v
	task bus(input w, input [7:0] a, input [31:0] v, input [1:0] er);
		begin
			@(posedge clk);
			if (w) begin
				awaddr <= a;
				wdata <= v;
				awvalid <= 1'b1;
				wvalid <= 1'b1;
				bready <= 1'b1;
			end else begin
				araddr <= a;
				arvalid <= 1'b1;
				rready <= 1'b1;
			end
			dn = 1'b0;
			n = 0;
			while (!dn) begin
				@(posedge clk);
				if (awready) awvalid <= 1'b0;
				if (wready) wvalid <= 1'b0;
				if (arready) arvalid <= 1'b0;
				if (bvalid || rvalid) begin
					dn = 1'b1;
					bready <= 1'b0;
					rready <= 1'b0;
					check(bvalid ? bresp : rresp, er);
					if (!w) check(rdata, v);
					check(n, w ? 2 : 1);
				end
				n = n + 1;
			end
		end
	endtask
	task print_verdict;
		begin
			$display("compares %0d mismatches %0d", cmp_count, fails);
			if (fails == 0 && cmp_count > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	// ==========
	// Tests
	initial begin
		seed = 32'hb7da2a4f;
		fails = 0;
		cmp_count = 0;
		{rst, nv, nc, ne, awaddr, araddr, wdata} = {1'b1, 72'h0};
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		check({result_q, result_err_q}, 0);
		bus(0, `OFS_CTRL, 32'h20, `RESP_OKAY);
		bus(0, `OFS_INT_MASK, 32'h0, `RESP_OKAY);
		$display("reset test done");
		for (f = 0; f < 6; f = f + 1)
			for (m = 0; m < 4; m = m + 1) begin
				bus(1, `OFS_CTRL, {26'h0, m[1:0], f[3:0]}, `RESP_OKAY);
				for (k = 0; k < 6; k = k + 1) begin
					@(posedge clk);
					nv <= (k == 2) ? 8'hFA : (k == 1) ? 8'hFF : $random(seed);
					nc <= (k == 0) ? 8'h00 : (k < 3) ? 8'h05 : $random(seed);
					ne <= (k < 4) ? 8'hF0 : $random(seed);
					repeat (3) @(posedge clk);
					mo = model_out(f, m, nv, nc, ne);
					check({result_q, result_err_q}, mo);
					if (k == 5) bus(0, `OFS_STATUS, {ne, nc, nv, 5'h0, nc == 8'h00 && f > 1, mo[0], mo[1]}, `RESP_OKAY);
				end
			end
		$display("function sweep done");
		bus(1, `OFS_CTRL, {28'h0, `FN_OR}, `RESP_OKAY);
		@(posedge clk);
		{nv, nc, ne} <= {8'h00, 8'hFF, 8'h00};
		repeat (4) @(posedge clk);
		bus(1, `OFS_INT_STAT, 32'hF, `RESP_OKAY);
		bus(1, `OFS_CHG_COUNT, 32'h0, `RESP_OKAY);
		bus(1, `OFS_INT_MASK, 32'h1, `RESP_OKAY);
		check(irq_q, 0);
		@(posedge clk);
		nv <= 8'h80;
		repeat (4) @(posedge clk);
		check(irq_q, 1);
		bus(0, `OFS_INT_STAT, 32'h1, `RESP_OKAY);
		bus(0, `OFS_CHG_COUNT, 32'h1, `RESP_OKAY);
		bus(1, `OFS_INT_MASK, 32'h0, `RESP_OKAY);
		repeat (2) @(posedge clk);
		check(irq_q, 0);
		bus(1, `OFS_INT_MASK, 32'h1, `RESP_OKAY);
		repeat (2) @(posedge clk);
		check(irq_q, 1);
		bus(1, `OFS_INT_STAT, 32'h1, `RESP_OKAY);
		repeat (2) @(posedge clk);
		check(irq_q, 0);
		bus(0, `OFS_INT_STAT, 32'h0, `RESP_OKAY);
		nv <= 8'h00;
		repeat (4) @(posedge clk);
		bus(0, `OFS_INT_STAT, 32'h2, `RESP_OKAY);
		$display("interrupt test done");
		bus(1, 8'h20, 32'h1, `RESP_SLVERR);
		bus(0, 8'h20, 32'h0, `RESP_SLVERR);
		$display("unmapped test done");
		print_verdict;
	end
	initial begin
		#2000000;
		fails = fails + 1;
		print_verdict;
	end
endmodule
